// *** core/ctc_core.sv ***
// Counting core of the control timer: enable protection, prescaler,
// up/down counter, commands and event actions, fault override.
// Assumes inputs synchronous to clk and events as one-cycle pulses.
`timescale 1ns/10ps
module ctc_core
   import ctc_pkg::*;
#(
   parameter int CNT_W  = CNT_W_DEF,   // Counter width
   parameter int CH_NUM = CH_NUM_DEF   // Waveform channels
)(
   input  wire logic              clk,           // 50 MHz clock
   input  wire logic              rst,           // Async reset, active high
   input  wire logic              ctl_wr,        // Control A write strobe
   input  wire logic              wr_enable,     // Enable bit value
   input  wire logic              wr_soft_reset, // Soft reset bit value
   input  wire logic [2:0]        wr_presc,      // Prescaler code
   input  wire logic [1:0]        wr_resync,     // Divider resync field
   input  wire logic              wr_one_shot,   // Single cycle bit
   input  wire logic              setup_wr,      // Event/driver setup write
   input  wire logic [2:0]        wr_ev0_act,    // Event zero action
   input  wire logic [2:0]        wr_ev1_act,    // Event one action
   input  wire logic              wr_trg_oe,     // Retrigger output enable
   input  wire logic [CH_NUM-1:0] wr_fault_oe,   // Fault override enables
   input  wire logic [CH_NUM-1:0] wr_fault_lvl,  // Fault levels
   input  wire logic              b_set_wr,      // Set alias write
   input  wire logic              b_clr_wr,      // Clear alias write
   input  wire logic              b_dir,         // Direction bit in alias
   input  wire logic [2:0]        b_cmd,         // Command field (set alias)
   input  wire logic              cnt_wr,        // Counter value write
   input  wire logic [CNT_W-1:0]  cnt_wdata,     // Counter value
   input  wire logic [CNT_W-1:0]  top_val,       // Cycle top value
   input  wire logic              input_event_zero, // Event zero pulse
   input  wire logic              input_event_one,  // Event one level/pulse
   input  wire logic              wrap_clr,      // Clear wrap flag
   input  wire logic              trg_clr,       // Clear retrigger flag
   input  wire logic [CH_NUM-1:0] wave_in,       // Waveform from generator
   output logic                   enabled,       // Timer enabled
   output logic [CNT_W-1:0]       count,         // Counter value
   output logic                   down,          // Down counting
   output logic                   stopped,       // Stop status
   output logic                   wrap_flag,     // Wrap flag
   output logic                   retrigger_flag,// Retrigger flag
   output logic                   trg_event,     // Retrigger output event
   output logic                   wrap_event,    // Wrap output pulse
   output logic                   sync_busy,     // Counter write pending
   output logic [CH_NUM-1:0]      wave_out       // Channel outputs
);
   // Elaboration guard: counter compares and steps are sized for these ranges
   if (CNT_W < 2 || CNT_W > 32 || CH_NUM < 1) begin : g_bad_param
      $error("ctc_core: unsupported parameters");
   end

   typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_RUN, ST_STOP} run_e;

   run_e              state_ff, nxt_state;     // Run state
   logic              en_ff;                   // Enable bit
   logic [2:0]        presc_ff;                // Prescaler code
   logic [1:0]        resync_ff;               // Resync field
   logic              one_shot_ff;             // Single cycle bit
   logic [2:0]        ev0_ff, ev1_ff;          // Event actions
   logic              trg_oe_ff;               // Retrigger output enable
   logic [CH_NUM-1:0] f_oe_ff, f_lvl_ff;       // Fault setup
   logic              dir_ff;                  // Programmed direction, 1 = down
   logic [CNT_W-1:0]  cnt_ff, nxt_cnt;         // Counter
   logic              wrap_ff, trg_ff;         // Sticky flags
   logic              trg_ev_ff, wrap_ev_ff;   // Output event pulses
   logic              pend_wrap_ff;            // Wrap waits for tick
   logic              busy_ff;                 // Registered sync busy
   logic [CH_NUM-1:0] wave_ff;                 // Registered outputs
   logic [CH_NUM-1:0] nxt_wave;                // Next channel outputs
   logic              forced_ff;               // Fault levels applied

   // Decoded write and event conditions
   wire soft_rst   = ctl_wr && wr_soft_reset;
   wire prot_ok    = ctl_wr && !en_ff && wr_enable;
   wire ctl_open   = ctl_wr && !en_ff;
   wire setup_ok   = setup_wr && !en_ff;
   wire sw_retrig  = b_set_wr && b_cmd == CMD_RETRIG;
   wire sw_stop    = b_set_wr && b_cmd == CMD_STOP;
   wire e0         = input_event_zero && en_ff;
   wire e1         = input_event_one && en_ff;
   wire ev_retrig  = (e0 && ev0_ff == ACT_RETRIG) || (e1 && ev1_ff == ACT_RETRIG);
   wire ev_start   = e0 && ev0_ff == ACT_START;
   wire ev_stop    = e1 && ev1_ff == ACT_STOP;
   wire ev_fault   = (e0 && ev0_ff == ACT_FAULT) || (e1 && ev1_ff == ACT_FAULT);
   wire ev_count   = e0 && ev0_ff == ACT_COUNT;
   wire ev_inc     = e0 && ev0_ff == ACT_INC;
   wire ev_dec     = e1 && ev1_ff == ACT_DEC;
   wire eff_down   = (ev1_ff == ACT_DIR && input_event_one) ? 1'b1 : dir_ff;
   wire event_mode = (ev0_ff == ACT_COUNT);
   wire retrig     = sw_retrig || ev_retrig;
   wire stop_req   = sw_stop || ev_stop || ev_fault;
   wire running    = (state_ff == ST_RUN);
   wire at_top     = (cnt_ff == top_val);
   wire at_zero    = (cnt_ff == '0);
   wire at_end     = eff_down ? at_zero : at_top;
   wire tick;
   // A stop in the same cycle wins over the step, so the count holds
   wire step       = running && !stop_req && (event_mode ? ev_count : tick);
   wire wrap_now   = step && at_end;
   wire do_wrap    = (resync_ff == RESYNC_GCLK || presc_ff == PRESC_RST) ? wrap_now
                     : (pend_wrap_ff && step);
   // Restart the divider on the wrap itself; holding it while at the end would stall the tick
   wire restart_p  = (resync_ff == RESYNC_RSTC) && do_wrap;
   wire wr_apply;
   wire [CNT_W-1:0] wr_val;
   wire wr_busy;
   wire [CNT_W-1:0] reload = eff_down ? top_val : '0;

   ctc_prescaler u_presc (
      .clk       (clk),
      .rst       (rst),
      .run       (running && !event_mode),
      .presc_sel (presc_ff),
      .restart   (restart_p),
      .tick      (tick)
   );

   ctc_write_sync #(.W(CNT_W)) u_wsync (
      .clk   (clk),
      .rst   (rst),
      .req   (cnt_wr),
      .din   (cnt_wdata),
      .busy  (wr_busy),
      .apply (wr_apply),
      .dout  (wr_val)
   );

   // Run state decode
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF:  if (prot_ok || (ctl_wr && wr_enable))
                     nxt_state = (ev0_ff == ACT_RETRIG || ev1_ff == ACT_RETRIG ||
                                  ev0_ff == ACT_START) ? ST_IDLE : ST_RUN;
         ST_IDLE: if (stop_req)
                     nxt_state = ST_STOP;
                  else if (retrig || ev_start)
                     nxt_state = ST_RUN;
         ST_RUN:  if (stop_req)
                     nxt_state = ST_STOP;
                  else if (one_shot_ff && do_wrap)
                     nxt_state = ST_STOP;
         ST_STOP: if (!ev_fault && (retrig || ev_start))
                     nxt_state = ST_RUN;
         default: nxt_state = ST_OFF;
      endcase
      if (ctl_wr && !wr_enable)
         nxt_state = ST_OFF;
      if (soft_rst)
         nxt_state = ST_OFF;
   end

   // Counter next value; bus write wins over every other action except soft reset
   always_comb begin
      nxt_cnt = cnt_ff;
      if (wr_apply)
         nxt_cnt = wr_val;
      else if (running && retrig)
         nxt_cnt = reload;
      else if (running && ev_inc)
         nxt_cnt = cnt_ff + CNT_W'(1);
      else if (running && ev_dec)
         nxt_cnt = cnt_ff - CNT_W'(1);
      else if (do_wrap)
         nxt_cnt = reload;
      else if (step && !at_end)
         nxt_cnt = eff_down ? cnt_ff - CNT_W'(1) : cnt_ff + CNT_W'(1);
      if (soft_rst)
         nxt_cnt = '0;
   end

   // Control settings; protected fields only while disabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_ff       <= 1'b0;
         presc_ff    <= PRESC_RST;
         resync_ff   <= RESYNC_RST;
         one_shot_ff <= 1'b0;
      end else if (soft_rst) begin
         en_ff       <= 1'b0;
         presc_ff    <= PRESC_RST;
         resync_ff   <= RESYNC_RST;
         one_shot_ff <= 1'b0;
      end else begin
         if (ctl_wr)
            en_ff <= wr_enable;
         if (ctl_open && wr_enable) begin
            presc_ff  <= wr_presc;
            resync_ff <= wr_resync;
         end
         if (b_set_wr && wr_one_shot)
            one_shot_ff <= 1'b1;
         else if (b_clr_wr && wr_one_shot)
            one_shot_ff <= 1'b0;
      end
   end

   // Event and driver setup, plus direction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ev0_ff    <= ACT_NONE;
         ev1_ff    <= ACT_NONE;
         trg_oe_ff <= 1'b0;
         f_oe_ff   <= '0;
         f_lvl_ff  <= '0;
         dir_ff    <= 1'b0;
      end else if (soft_rst) begin
         ev0_ff    <= ACT_NONE;
         ev1_ff    <= ACT_NONE;
         trg_oe_ff <= 1'b0;
         f_oe_ff   <= '0;
         f_lvl_ff  <= '0;
         dir_ff    <= 1'b0;
      end else begin
         if (setup_ok) begin
            ev0_ff    <= wr_ev0_act;
            ev1_ff    <= wr_ev1_act;
            trg_oe_ff <= wr_trg_oe;
            f_oe_ff   <= wr_fault_oe;
            f_lvl_ff  <= wr_fault_lvl;
         end
         if (b_set_wr && b_dir)
            dir_ff <= 1'b1;
         else if (b_clr_wr && b_dir)
            dir_ff <= 1'b0;
      end
   end

   // Counter, flags and pulses; a set beats a same-cycle clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff     <= ST_OFF;
         cnt_ff       <= '0;
         wrap_ff      <= 1'b0;
         trg_ff       <= 1'b0;
         trg_ev_ff    <= 1'b0;
         wrap_ev_ff   <= 1'b0;
         pend_wrap_ff <= 1'b0;
         busy_ff      <= 1'b0;
         forced_ff    <= 1'b0;
         wave_ff      <= '0;
      end else begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         busy_ff      <= wr_busy || cnt_wr;
         pend_wrap_ff <= soft_rst ? 1'b0 : (wrap_now || (pend_wrap_ff && !do_wrap));
         wrap_ff      <= !soft_rst && (do_wrap || (wrap_ff && !wrap_clr));
         trg_ff       <= !soft_rst && ((running && retrig) || (trg_ff && !trg_clr));
         trg_ev_ff    <= running && retrig && trg_oe_ff;
         wrap_ev_ff   <= do_wrap;
         forced_ff    <= !soft_rst && (nxt_state == ST_STOP);
         wave_ff      <= nxt_wave;
      end
   end

   // Per-channel output select: an overridden channel shows its fault level
   for (genvar g = 0; g < CH_NUM; g++) begin : g_chan
      assign nxt_wave[g] = (nxt_state == ST_STOP && f_oe_ff[g]) ? f_lvl_ff[g] : wave_in[g];
   end

   assign enabled        = en_ff;
   assign count          = cnt_ff;
   assign down           = dir_ff;
   assign stopped        = forced_ff;
   assign wrap_flag      = wrap_ff;
   assign retrigger_flag = trg_ff;
   assign trg_event      = trg_ev_ff;
   assign wrap_event     = wrap_ev_ff;
   assign sync_busy      = busy_ff;
   assign wave_out       = wave_ff;

   // Checks
   a_prot_hold: assert property (@(posedge clk) disable iff (rst)
      en_ff && setup_wr && !soft_rst |=> $stable(ev0_ff) && $stable(ev1_ff) && $stable(f_oe_ff))
      else $error("setup changed while enabled");
   a_soft_off: assert property (@(posedge clk) disable iff (rst)
      soft_rst |=> !en_ff && state_ff == ST_OFF) else $error("soft reset left timer on");
   a_write_wins: assert property (@(posedge clk) disable iff (rst)
      wr_apply && !soft_rst |=> cnt_ff == $past(wr_val)) else $error("counter write lost");
   a_stop_hold: assert property (@(posedge clk) disable iff (rst)
      state_ff == ST_STOP && nxt_state == ST_STOP && !wr_apply && !soft_rst |=> $stable(cnt_ff))
      else $error("stopped counter moved");
   a_wrap_set: assert property (@(posedge clk) disable iff (rst)
      do_wrap && !soft_rst |=> wrap_ff) else $error("wrap flag not set");
   a_retrig_clr: assert property (@(posedge clk) disable iff (rst)
      running && retrig && !wr_apply && !eff_down && !soft_rst |=> cnt_ff == '0 && trg_ff)
      else $error("retrigger did not clear");
   a_one_shot: assert property (@(posedge clk) disable iff (rst)
      running && one_shot_ff && do_wrap && !ctl_wr |=> state_ff == ST_STOP)
      else $error("one-shot did not stop");
   a_fault_out: assert property (@(posedge clk) disable iff (rst)
      ev_fault && !soft_rst && !(ctl_wr && !wr_enable)
      |=> wave_out == ((f_lvl_ff & f_oe_ff) | ($past(wave_in) & ~f_oe_ff)))
      else $error("fault levels not forced");
   a_inc_event: assert property (@(posedge clk) disable iff (rst)
      running && ev_inc && !wr_apply && !retrig && !soft_rst |=> cnt_ff == $past(cnt_ff) + CNT_W'(1))
      else $error("increment event missed");
   c_wrap: cover property (@(posedge clk) disable iff (rst) do_wrap);
   c_stop: cover property (@(posedge clk) disable iff (rst) running && stop_req);
   c_resume: cover property (@(posedge clk) disable iff (rst) state_ff == ST_STOP && retrig);
   c_one_shot: cover property (@(posedge clk) disable iff (rst) one_shot_ff && do_wrap);
endmodule

// *** core/ctc_pkg.sv ***
// Constants shared by the control timer counting core.
// Assumes one 50 MHz clock and plain control ports, no register bus.
// Overview of operation
// - Protected settings written only while disabled
// - Protected bits accepted with enable set
// - Enable bit turns timer on or off
// - Soft reset restores settings, disables timer
// - Prescaler divides clock, one to 1024
// - Resync selects prescaler restart and wrap tick
// - Counted events bypass the prescaler
// - Counter clears, reloads, increments or decrements
// - Top or zero sets wrap, one-shot stops
// - Clear alias counts up, set alias down
// - Counter write wins over all but soft reset, applied after sync
// - Stop holds count, forces fault outputs
// - Retrigger clears or reloads, flags, emits event
// - Retrigger while stopped resumes counting
// - Retrigger action waits for first event
// - Start event starts an idle or stopped counter
// - Count event steps in current direction
// - Direction event overrides programmed direction
// - Increment event adds one while running, unless written or retriggered
// - Decrement event subtracts one while running, unless written, retriggered or incremented
// - Fault event stops counter, forces outputs
// - Counter writes cross two sync stages
// - Counter compared to top and zero
package ctc_pkg;
   localparam int           CNT_W_DEF   = 24;     // Counter width
   localparam int           CH_NUM_DEF  = 4;      // Waveform outputs
   localparam int           SYNC_STAGES = 2;      // Write crossing depth
   localparam logic [2:0]   PRESC_RST   = 3'h0;   // Undivided after reset
   localparam logic [1:0]   RESYNC_RST  = 2'h0;   // Wrap on generic clock
   // Divider resync field codes
   localparam logic [1:0]   RESYNC_GCLK = 2'h0;   // Wrap on next generic clock
   localparam logic [1:0]   RESYNC_TICK = 2'h1;   // Wrap on next prescaled tick
   localparam logic [1:0]   RESYNC_RSTC = 2'h2;   // Restart prescaler on wrap
   // Software commands
   localparam logic [2:0]   CMD_NONE    = 3'h0;
   localparam logic [2:0]   CMD_RETRIG  = 3'h1;
   localparam logic [2:0]   CMD_STOP    = 3'h2;
   // Event actions, one code space for both inputs
   localparam logic [2:0]   ACT_NONE    = 3'h0;
   localparam logic [2:0]   ACT_RETRIG  = 3'h1;
   localparam logic [2:0]   ACT_START   = 3'h2;
   localparam logic [2:0]   ACT_COUNT   = 3'h3;
   localparam logic [2:0]   ACT_DIR     = 3'h4;
   localparam logic [2:0]   ACT_INC     = 3'h5;
   localparam logic [2:0]   ACT_DEC     = 3'h6;
   localparam logic [2:0]   ACT_FAULT   = 3'h7;
   localparam logic [2:0]   ACT_STOP    = 3'h2;   // Input one reuses start's code
endpackage

// *** core/ctc_prescaler.sv ***
// Prescaler: divides the clock into a one-cycle tick enable.
// Assumes the counting core drives enable and restart requests.
`timescale 1ns/10ps
module ctc_prescaler
   import ctc_pkg::*;
(
   input  wire logic       clk,        // 50 MHz clock
   input  wire logic       rst,        // Async reset, active high
   input  wire logic       run,        // Timer running and not counting events
   input  wire logic [2:0] presc_sel,  // Ratio code 1,2,4,8,16,64,256,1024
   input  wire logic       restart,    // Zero the divider on wrap
   output logic            tick        // Prescaled tick enable
);
   logic [9:0] div_ff;                 // Divider count
   logic [9:0] lim;                    // Terminal count for selected ratio
   logic       at_lim;                 // Divider reached its terminal count

   // Ratio table as a decode
   always_comb begin
      case (presc_sel)
         3'h0:    lim = 10'h000;
         3'h1:    lim = 10'h001;
         3'h2:    lim = 10'h003;
         3'h3:    lim = 10'h007;
         3'h4:    lim = 10'h00F;
         3'h5:    lim = 10'h03F;
         3'h6:    lim = 10'h0FF;
         default: lim = 10'h3FF;
      endcase
   end

   assign at_lim = (div_ff >= lim);
   assign tick   = run && at_lim;

   // Count up to the limit, then roll over; restart zeroes it
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         div_ff <= 10'h000;
      else if (!run || restart || at_lim)
         div_ff <= 10'h000;
      else
         div_ff <= div_ff + 10'h001;
   end
endmodule

// *** core/ctc_write_sync.sv ***
// Counter write crossing: holds a value and releases it after a delay.
// Assumes requests are spaced by at least the stage count.
`timescale 1ns/10ps
module ctc_write_sync
   import ctc_pkg::*;
#(
   parameter int W = CNT_W_DEF         // Value width
)(
   input  wire logic         clk,      // Clock
   input  wire logic         rst,      // Async reset, active high
   input  wire logic         req,      // Write request pulse
   input  wire logic [W-1:0] din,      // Written value
   output logic              busy,     // Crossing in progress
   output logic              apply,    // One-cycle apply pulse
   output logic [W-1:0]      dout      // Value to load
);
   logic [SYNC_STAGES-1:0] pipe_ff;    // Request travelling through stages
   logic [W-1:0]           hold_ff;    // Captured value

   // Elaboration guard: the shift below needs two stages at least
   if (W < 1 || SYNC_STAGES < 2) begin : g_bad_param
      $error("ctc_write_sync: unsupported parameters");
   end

   // Shift the request; capture data at the start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pipe_ff <= '0;
         hold_ff <= '0;
      end else begin
         pipe_ff <= {pipe_ff[SYNC_STAGES-2:0], req};
         if (req)
            hold_ff <= din;
      end
   end

   assign busy  = |pipe_ff;
   assign apply = pipe_ff[SYNC_STAGES-1];
   assign dout  = hold_ff;
endmodule

// *** dv/ctc_core_tb.sv ***
// Bench for the timer counting core: one task per scenario, one compare task.
// Assumes the core, its package and the event source model compile first.
`timescale 1ns/10ps
module ctc_core_tb;
   import ctc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ctl_wr = 1'b0, en = 1'b0, srst = 1'b0;  // Clock, reset, control A
   logic setup_wr = 1'b0, set_wr = 1'b0, clr_wr = 1'b0, dir = 1'b0;       // Strobes
   logic cnt_wr = 1'b0, f0 = 1'b0, f1 = 1'b0, ev0, ev1;                     // Counter write, events
   logic os = 1'b0, fclr = 1'b0, trg_ev, wrap_ev;                           // One-shot, flag clear, pulses
   int trg_pulses = 0;                                                     // Retrigger pulses seen
   logic [2:0] a0 = ACT_NONE, a1 = ACT_NONE, cmd = CMD_NONE, presc = PRESC_RST;
   logic [3:0] oe = 4'h0, lvl = 4'h0, wave_out;                            // Fault override setup
   logic [23:0] wdata = 24'h0, top = 24'h3, count;                         // Counter values
   logic enabled, down, stopped, wrap_flag, trg_flag, sync_busy;           // Status outputs
   int fail_count = 0, check_count = 0;                                    // Tallies
   logic [23:0] held;                                                      // Count seen at stop

   // Event network partner
   ctc_event_src u_ev (.clk(clk), .fire0(f0), .fire1(f1), .ev0(ev0), .ev1(ev1));

   // Resync and waveform source are tied off to save bench length
   ctc_core u_dut (.clk(clk), .rst(rst), .ctl_wr(ctl_wr), .wr_enable(en), .wr_soft_reset(srst),
      .wr_presc(presc), .wr_resync(RESYNC_RST), .wr_one_shot(os), .setup_wr(setup_wr),
      .wr_ev0_act(a0), .wr_ev1_act(a1), .wr_trg_oe(1'b1), .wr_fault_oe(oe), .wr_fault_lvl(lvl),
      .b_set_wr(set_wr), .b_clr_wr(clr_wr), .b_dir(dir), .b_cmd(cmd), .cnt_wr(cnt_wr),
      .cnt_wdata(wdata), .top_val(top), .input_event_zero(ev0), .input_event_one(ev1),
      .wrap_clr(fclr), .trg_clr(fclr), .wave_in(4'h5), .enabled(enabled), .count(count),
      .down(down), .stopped(stopped), .wrap_flag(wrap_flag), .retrigger_flag(trg_flag),
      .trg_event(trg_ev), .wrap_event(wrap_ev), .sync_busy(sync_busy), .wave_out(wave_out));

   // 50 MHz clock
   always #10 clk = ~clk;

   // Count retrigger output pulses edge by edge, so a pulse between two checks is not lost
   always @(posedge clk) trg_pulses <= trg_pulses + int'(trg_ev);

   // Inputs change 1 ns after the rising edge so the core samples settled values
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Compare seen against expected with four-state equality
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Control A write, result visible one cycle later
   task ctl(input logic e, input logic s);
      en = e;
      srst = s;
      ctl_wr = 1'b1;
      step(1);
      ctl_wr = 1'b0;
      step(1);
   endtask

   // Event and driver setup write
   task setup(input logic [2:0] x0, input logic [2:0] x1, input logic [3:0] o, input logic [3:0] l);
      a0 = x0;
      a1 = x1;
      oe = o;
      lvl = l;
      setup_wr = 1'b1;
      step(1);
      setup_wr = 1'b0;
      step(1);
   endtask

   // Set alias (command, direction) or clear alias write
   task alias_wr(input logic setw, input logic d, input logic [2:0] c);
      dir = d;
      cmd = c;
      set_wr = setw;
      clr_wr = ~setw;
      step(1);
      {set_wr, clr_wr, cmd} = {2'b00, CMD_NONE};
      step(1);
   endtask

   // One event pulse through the partner, which adds one cycle
   task fire(input logic one);
      {f1, f0} = one ? 2'b10 : 2'b01;
      step(1);
      {f1, f0} = 2'b00;
      step(2);
   endtask

   task t_reset;
      chk("enabled", enabled, 0);
      chk("count", count, 0);
      chk("wave_out", wave_out, 4'h5);
   endtask

   task t_wrap;
      ctl(1'b1, 1'b0);
      chk("enabled", enabled, 1);
      for (int i = 0; i < 40 && count !== top; i++) step(1);
      chk("count top", count, top);
      step(1);
      chk("count wrap", count, 0);
      chk("wrap_flag", wrap_flag, 1);
      chk("wrap_event", wrap_ev, 1);
      fclr = 1'b1;
      step(1);
      fclr = 1'b0;
      chk("wrap_flag clr", wrap_flag, 0);
   endtask

   task t_fault;
      ctl(1'b0, 1'b0);
      setup(ACT_NONE, ACT_FAULT, 4'hF, 4'hA);
      ctl(1'b1, 1'b0);
      fire(1'b1);
      chk("stopped", stopped, 1);
      chk("wave_out", wave_out, 4'hA);
      held = count;
      setup(ACT_NONE, ACT_NONE, 4'h0, 4'h0);
      chk("wave_out kept", wave_out, 4'hA);
      chk("count held", count, held);
      alias_wr(1'b1, 1'b0, CMD_RETRIG);
      chk("stopped resume", stopped, 0);
      alias_wr(1'b1, 1'b0, CMD_RETRIG);
      chk("retrigger_flag", trg_flag, 1);
      chk("trg_event pulses", trg_pulses, 1);
      fclr = 1'b1;
      step(1);
      fclr = 1'b0;
      chk("retrigger_flag clr", trg_flag, 0);
   endtask

   task t_dir;
      alias_wr(1'b1, 1'b1, CMD_NONE);
      chk("down set", down, 1);
      alias_wr(1'b0, 1'b1, CMD_NONE);
      chk("down clr", down, 0);
      alias_wr(1'b1, 1'b1, CMD_NONE);
      os = 1'b1;
      alias_wr(1'b1, 1'b1, CMD_NONE);
      os = 1'b0;
      for (int i = 0; i < 10 && stopped !== 1'b1; i++) step(1);
      chk("one-shot stop", stopped, 1);
      os = 1'b1;
      alias_wr(1'b0, 1'b0, CMD_NONE);
      os = 1'b0;
   endtask

   task t_events;
      ctl(1'b0, 1'b0);
      top = 24'hFF;
      setup(ACT_COUNT, ACT_DEC, 4'h0, 4'h0);
      wdata = 24'h000005;
      cnt_wr = 1'b1;
      step(1);
      cnt_wr = 1'b0;
      for (int i = 0; i < 10 && sync_busy !== 1'b0; i++) step(1);
      step(1);
      chk("count write", count, 24'h000005);
      alias_wr(1'b0, 1'b1, CMD_NONE);
      ctl(1'b1, 1'b0);
      repeat (3) fire(1'b0);
      chk("count events", count, 24'h000008);
      fire(1'b1);
      chk("count dec", count, 24'h000007);
      ctl(1'b0, 1'b0);
      setup(ACT_INC, ACT_STOP, 4'h0, 4'h0);
      ctl(1'b1, 1'b0);
      fire(1'b0);
      fire(1'b1);
      chk("stopped by event", stopped, 1);
      held = count;
      step(2);
      chk("count held ev", count, held);
   endtask

   task t_soft;
      alias_wr(1'b1, 1'b1, CMD_NONE);
      ctl(1'b0, 1'b0);
      ctl(1'b0, 1'b1);
      chk("enabled", enabled, 0);
      chk("down", down, 0);
   endtask

   // Single exit point for the normal end and the watchdog
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence
   initial begin
      step(12);
      rst = 1'b0;
      step(1);
      t_reset();
      t_wrap();
      t_fault();
      t_dir();
      t_events();
      t_soft();
      end_sim();
   end

   // The scenarios need well under 1000 cycles
   initial begin
      #100us;
      fail_count++;
      end_sim();
   end
endmodule

// *** dv/ctc_event_src.sv ***
// Event network model: turns requests from the bench into event pulses.
// Assumes the core takes both events as one-cycle pulses on its clock.
`timescale 1ns/10ps
module ctc_event_src (
   input  wire logic clk,    // Core clock
   input  wire logic fire0,  // Request for event zero
   input  wire logic fire1,  // Request for event one
   output logic      ev0,    // Event zero pulse
   output logic      ev1     // Event one pulse
);
   // One register stage stands in for the routing delay of the network
   always_ff @(posedge clk) begin
      ev0 <= fire0;
      ev1 <= fire1;
   end
endmodule
